// File: rtl/smwp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Optimized float overlaps next access setup
// - Unoptimized float waits appended after reads
// - Read hold cycles count toward float
// - Wait select 10 frozen, 11 ready, 00 off
// - Wait sampled only in strobe pulse phase
// - Frozen wait halts counters and outputs
// - Ready wait checked in last pulse cycle
// - Early release or late wait: no stretch
// - Slow clock overrides programmed timings
// - Slow reads: setup 1, pulse 1, cycle 2
// - Slow writes: setup 1, pulse 1, cycle 3
// - Running transfer keeps its parameter set
// - Page reads only when enabled, 4-32 bytes
// - Page address is bits above offset
// - Offset ignores low bits per device width
// - Page mode: strobe and select stay low
// - First page access uses cs read width
// - Page mode ignores read setups and cycle
// - Page timings applied without checking
// - Byte select kind stays in force
// - Float count spans 0 to 15 cycles
// - New page on address or select change
module smwp_ctrl
	import smwp_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	input  wire logic                 req,
	input  wire logic                 req_write,
	input  wire logic [SMWP_CSW-1:0]  req_cs,
	input  wire logic [SMWP_AW-1:0]   req_addr,
	input  wire logic                 slow_clock,
	input  wire logic                 external_wait_n,
	input  wire logic [1:0]           external_wait_select,
	input  wire logic                 float_opt,
	input  wire logic [3:0]           float_cycles,
	input  wire logic                 page_enable,
	input  wire logic [1:0]           page_size_field,
	input  wire logic [1:0]           data_width,
	input  wire logic                 byte_access_kind,
	input  wire logic [SMWP_TW-1:0]   read_strobe_setup,
	input  wire logic [SMWP_TW-1:0]   read_strobe_width,
	input  wire logic [SMWP_TW-1:0]   read_strobe_hold,
	input  wire logic [SMWP_TW-1:0]   cs_read_setup,
	input  wire logic [SMWP_TW-1:0]   cs_read_width,
	input  wire logic [SMWP_TW-1:0]   read_cycle_length,
	input  wire logic [SMWP_TW-1:0]   write_strobe_setup,
	input  wire logic [SMWP_TW-1:0]   write_strobe_width,
	input  wire logic [SMWP_TW-1:0]   cs_write_setup,
	input  wire logic [SMWP_TW-1:0]   cs_write_width,
	input  wire logic [SMWP_TW-1:0]   write_cycle_length,
	output logic                      req_ready,
	output logic                      done,
	output logic                      chip_select_n,
	output logic [SMWP_CSW-1:0]       cs_index,
	output logic                      read_strobe_n,
	output logic                      write_strobe_n,
	output logic                      byte_select_mode,
	output logic                      page_hit,
	output logic                      wait_frozen
);
	////////////////////////////////////////////////////////////////////////////
	// Wait synchroniser
	smwp_if wif ();
	assign wif.wait_raw_n = external_wait_n;
	smwp_wait_sync u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.w     (wif.sync)
	);

	function automatic logic [SMWP_AW-1:0] page_mask(input logic [1:0] ps);
		logic [SMWP_AW-1:0] m;
		m = {SMWP_AW{1'b1}};
		page_mask = m << ({1'b0, ps} + 3'h2);
	endfunction : page_mask

	////////////////////////////////////////////////////////////////////////////
	// State
	smwp_state_t            st_r, st_nxt;
	logic [SMWP_TW-1:0]     cnt_r;
	logic [SMWP_TW-1:0]     stb_set_r, stb_end_r, cs_set_r, cs_end_r, cyc_r;
	logic                   wr_r;
	logic [1:0]             wsel_r;
	logic [3:0]             flt_r;
	logic                   fopt_r;
	logic [SMWP_TW-1:0]     hold_r;
	logic [SMWP_AW-1:0]     page_r;
	logic [SMWP_CSW-1:0]    pcs_r;
	logic                   pvalid_r;
	logic                   rdy_hold_r;

	////////////////////////////////////////////////////////////////////////////
	// Parameter set chosen at access start
	wire logic [SMWP_AW-1:0] pmask    = page_mask(page_size_field);
	wire logic               same_pg  = pvalid_r && pcs_r == req_cs &&
		(req_addr & pmask) == (page_r & pmask);
	wire logic               use_page = page_enable && !req_write &&
		!slow_clock;
	wire logic               pg_first = !same_pg;
	wire logic [SMWP_TW-1:0] pg_len   = pg_first ? cs_read_width :
		read_strobe_width;
	wire logic [SMWP_TW-1:0] s_set = slow_clock ? SMWP_SLOW_STB_SETUP :
		(req_write ? write_strobe_setup : read_strobe_setup);
	wire logic [SMWP_TW-1:0] s_wid = slow_clock ? SMWP_SLOW_STB_WIDTH :
		(req_write ? write_strobe_width : read_strobe_width);
	wire logic [SMWP_TW-1:0] c_set = slow_clock ? SMWP_SLOW_CS_SETUP :
		(req_write ? cs_write_setup : cs_read_setup);
	wire logic [SMWP_TW-1:0] c_wid = slow_clock ?
		(req_write ? SMWP_SLOW_WR_CS_W : SMWP_SLOW_RD_CS_W) :
		(req_write ? cs_write_width : cs_read_width);
	wire logic [SMWP_TW-1:0] cyc   = slow_clock ?
		(req_write ? SMWP_SLOW_WR_CYCLE : SMWP_SLOW_RD_CYCLE) :
		(req_write ? write_cycle_length : read_cycle_length);
	// Low address bits dropped by width are simply outside page compare
	wire logic [1:0] ign_lsb = data_width == SMWP_DW_8 ? 2'h0 :
		(data_width == SMWP_DW_16 ? 2'h1 : 2'h2);

	////////////////////////////////////////////////////////////////////////////
	// Phase decode
	wire logic in_pulse   = st_r == SMWP_RUN && cnt_r >= stb_set_r &&
		cnt_r < stb_end_r;
	wire logic last_pulse = st_r == SMWP_RUN &&
		cnt_r == stb_end_r - SMWP_ONE;
	wire logic frz = wsel_r == SMWP_WAIT_FROZEN && in_pulse &&
		wif.wait_sync;
	wire logic rdy = wsel_r == SMWP_WAIT_READY && last_pulse &&
		wif.wait_sync;
	wire logic run_end  = st_r == SMWP_RUN && cnt_r + SMWP_ONE >= cyc_r;
	wire logic pg_end   = st_r == SMWP_PAGE && cnt_r + SMWP_ONE >= cyc_r;
	// Float cycles left after hold already elapsed
	wire logic [SMWP_TW-1:0] flt_rem = {5'h0, flt_r} > hold_r ?
		{5'h0, flt_r} - hold_r : SMWP_ZERO;
	wire logic need_flt = !wr_r && !fopt_r && flt_rem != SMWP_ZERO;
	wire logic [SMWP_TW-1:0] cs_lo_s = cs_set_r;
	wire logic [SMWP_TW-1:0] cs_lo_e = cs_end_r;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			SMWP_IDLE: begin
				if (req)
					st_nxt = use_page ? SMWP_PAGE : SMWP_RUN;
			end
			SMWP_RUN: begin
				if (frz || rdy)
					st_nxt = SMWP_HELD;
				else if (run_end)
					st_nxt = need_flt ? SMWP_FLOAT : SMWP_IDLE;
			end
			SMWP_HELD: begin
				if (!wif.wait_sync)
					st_nxt = SMWP_RUN;
			end
			SMWP_PAGE: begin
				if (pg_end)
					st_nxt = need_flt ? SMWP_FLOAT : SMWP_IDLE;
			end
			SMWP_FLOAT: begin
				if (cnt_r + SMWP_ONE >= flt_rem)
					st_nxt = SMWP_IDLE;
			end
			default: st_nxt = SMWP_IDLE;
		endcase
	end

	wire logic start = st_r == SMWP_IDLE && req;
	wire logic held_go = st_r == SMWP_HELD && !wif.wait_sync;
	wire logic leave = (st_r == SMWP_RUN && !frz && !rdy && run_end) ||
		pg_end;
	// Ready resume skips remaining pulse count into hold
	wire logic [SMWP_TW-1:0] cnt_step = cnt_r + SMWP_ONE;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= SMWP_IDLE;
			cnt_r <= SMWP_ZERO;
		end else if (ce) begin
			st_r <= st_nxt;
			if (start || leave)
				cnt_r <= SMWP_ZERO;
			else if (st_r == SMWP_HELD)
				cnt_r <= held_go && rdy_hold_r ? cnt_step : cnt_r;
			else if (!frz && !rdy)
				cnt_r <= cnt_step;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdy_hold_r <= 1'b0;
		end else if (ce) begin
			if (rdy)
				rdy_hold_r <= 1'b1;
			else if (frz)
				rdy_hold_r <= 1'b0;
		end
	end

	// Captured set stays until access ends, even if slow clock drops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stb_set_r <= SMWP_ZERO;
			stb_end_r <= SMWP_ZERO;
			cs_set_r <= SMWP_ZERO;
			cs_end_r <= SMWP_ZERO;
			cyc_r <= SMWP_ZERO;
			wr_r <= 1'b0;
			wsel_r <= SMWP_WAIT_OFF;
			flt_r <= 4'h0;
			fopt_r <= 1'b0;
			hold_r <= SMWP_ZERO;
		end else if (ce && start) begin
			stb_set_r <= use_page ? SMWP_ZERO : s_set;
			stb_end_r <= use_page ? pg_len : s_set + s_wid;
			cs_set_r <= use_page ? SMWP_ZERO : c_set;
			cs_end_r <= use_page ? pg_len : c_set + c_wid;
			cyc_r <= use_page ? pg_len : cyc;
			wr_r <= req_write;
			wsel_r <= (slow_clock || use_page) ? SMWP_WAIT_OFF :
				external_wait_select;
			flt_r <= float_cycles;
			fopt_r <= float_opt;
			hold_r <= (use_page || slow_clock) ? SMWP_ZERO :
				read_strobe_hold;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Page tracking
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			page_r <= {SMWP_AW{1'b0}};
			pcs_r <= {SMWP_CSW{1'b0}};
			pvalid_r <= 1'b0;
		end else if (ce) begin
			if (start && use_page) begin
				page_r <= req_addr;
				pcs_r <= req_cs;
				pvalid_r <= 1'b1;
			end else if (start || (st_r == SMWP_IDLE && !req)) begin
				pvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	wire logic act  = st_r == SMWP_RUN || st_r == SMWP_HELD;
	wire logic cs_on = st_r == SMWP_PAGE ||
		(act && cnt_r >= cs_lo_s && cnt_r < cs_lo_e);
	wire logic st_on = st_r == SMWP_PAGE ||
		(act && cnt_r >= stb_set_r && cnt_r < stb_end_r);
	wire logic fin_nxt = (leave && !need_flt) ||
		(st_r == SMWP_FLOAT && st_nxt == SMWP_IDLE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chip_select_n <= 1'b1;
			read_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			cs_index <= {SMWP_CSW{1'b0}};
			req_ready <= 1'b0;
			done <= 1'b0;
			byte_select_mode <= 1'b0;
			page_hit <= 1'b0;
			wait_frozen <= 1'b0;
		end else if (ce) begin
			chip_select_n <= !cs_on;
			read_strobe_n <= !(st_on && !wr_r);
			write_strobe_n <= !(st_on && wr_r);
			if (start)
				cs_index <= req_cs;
			req_ready <= st_nxt == SMWP_IDLE;
			done <= fin_nxt;
			byte_select_mode <= byte_access_kind;
			page_hit <= start && use_page && same_pg;
			wait_frozen <= st_nxt == SMWP_HELD;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_off_no_hold: assert property (@(posedge clk) disable iff (!rst_n)
		wsel_r == SMWP_WAIT_OFF |-> st_nxt != SMWP_HELD)
		else $error("wait honoured while disabled");
	a_wait_pulse_only: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r == SMWP_RUN && st_nxt == SMWP_HELD) |-> in_pulse)
		else $error("wait taken outside pulse");
	a_frozen_cnt: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && frz) |=> (cnt_r == $past(cnt_r) && st_r == SMWP_HELD))
		else $error("counter moved while frozen");
	a_ready_last: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && st_r == SMWP_HELD && wsel_r == SMWP_WAIT_READY &&
		!wif.wait_sync) |=> cnt_r == stb_end_r)
		else $error("ready release did not enter hold");
	a_ready_clean: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && st_r == SMWP_RUN && last_pulse && !wif.wait_sync &&
		wsel_r == SMWP_WAIT_READY) |=> st_r != SMWP_HELD)
		else $error("access stretched without wait");
	a_slow_setup: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && start && slow_clock && !req_write) |=>
		(stb_set_r == SMWP_SLOW_STB_SETUP &&
		cyc_r == SMWP_SLOW_RD_CYCLE))
		else $error("slow read timing wrong");
	a_slow_write: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && start && slow_clock && req_write) |=>
		(cs_end_r == SMWP_SLOW_WR_CS_W && cyc_r == SMWP_SLOW_WR_CYCLE))
		else $error("slow write timing wrong");
	a_page_len: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && start && use_page) |=>
		cyc_r == (page_hit ? read_strobe_width : cs_read_width))
		else $error("page access length wrong");
	a_page_low: assert property (@(posedge clk) disable iff (!rst_n)
		st_r == SMWP_PAGE |=> (!chip_select_n && !read_strobe_n))
		else $error("page strobes not low");
	a_float_opt: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r != SMWP_FLOAT && st_nxt == SMWP_FLOAT) |-> !fopt_r)
		else $error("float wait with optimization");
	c_frozen: cover property (@(posedge clk) disable iff (!rst_n) frz);
	c_ready: cover property (@(posedge clk) disable iff (!rst_n) rdy);
	c_page_hit: cover property (@(posedge clk) disable iff (!rst_n)
		page_hit);
	c_float: cover property (@(posedge clk) disable iff (!rst_n)
		st_r == SMWP_FLOAT);
endmodule : smwp_ctrl
`default_nettype wire

// File: rtl/smwp_pkg.sv
package smwp_pkg;
	localparam int SMWP_TW         = 9;
	localparam int SMWP_AW         = 26;
	localparam int SMWP_CSW        = 3;
	localparam logic [1:0] SMWP_WAIT_OFF    = 2'h0;
	localparam logic [1:0] SMWP_WAIT_FROZEN = 2'h2;
	localparam logic [1:0] SMWP_WAIT_READY  = 2'h3;
	localparam logic [8:0] SMWP_SLOW_STB_SETUP = 9'h001;
	localparam logic [8:0] SMWP_SLOW_STB_WIDTH = 9'h001;
	localparam logic [8:0] SMWP_SLOW_CS_SETUP  = 9'h000;
	localparam logic [8:0] SMWP_SLOW_RD_CS_W   = 9'h002;
	localparam logic [8:0] SMWP_SLOW_WR_CS_W   = 9'h003;
	localparam logic [8:0] SMWP_SLOW_RD_CYCLE  = 9'h002;
	localparam logic [8:0] SMWP_SLOW_WR_CYCLE  = 9'h003;
	localparam logic [8:0] SMWP_ONE            = 9'h001;
	localparam logic [8:0] SMWP_ZERO           = 9'h000;
	localparam logic [3:0] SMWP_TDF_MAX        = 4'hF;
	localparam logic [1:0] SMWP_DW_8           = 2'h0;
	localparam logic [1:0] SMWP_DW_16          = 2'h1;
	typedef enum logic [2:0] {
		SMWP_IDLE  = 3'b000,
		SMWP_RUN   = 3'b001,
		SMWP_PAGE  = 3'b010,
		SMWP_FLOAT = 3'b011,
		SMWP_HELD  = 3'b100
	} smwp_state_t;
endpackage : smwp_pkg

// File: rtl/smwp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface smwp_if;
	logic       wait_sync;
	logic       wait_raw_n;
	modport sync (input wait_raw_n, output wait_sync);
	modport core (output wait_raw_n, input wait_sync);
endinterface : smwp_if
`default_nettype wire

// File: rtl/smwp_wait_sync.sv
`timescale 1ns/100ps
`default_nettype none
module smwp_wait_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	smwp_if.sync      w
);
	logic meta_r;
	logic sync_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
		end else if (ce) begin
			meta_r <= w.wait_raw_n;
			sync_r <= meta_r;
		end
	end
	// Synchronised wait, active high
	assign w.wait_sync = ~sync_r;
endmodule : smwp_wait_sync
`default_nettype wire

// File: test/smwp_mem.sv
`timescale 1ns/100ps
`default_nettype none
module smwp_mem (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       chip_select_n,
	input  wire logic [7:0] wait_delay,
	input  wire logic [7:0] wait_len,
	output logic            external_wait_n
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic       hold_low;
	////////////////////////////////////////////////////////////////////////
	// Cycles since select, wait window, pull-up when released
	assign cnt_nxt  = chip_select_n ? 8'h00 : cnt_r + 8'h01;
	assign hold_low = !chip_select_n && wait_len != 8'h00 &&
		cnt_r >= wait_delay && cnt_r < wait_delay + wait_len;
	assign external_wait_n = !hold_low;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= 8'h00;
		else
			cnt_r <= cnt_nxt;
	end
endmodule : smwp_mem
`default_nettype wire

// File: test/tb_static_mem_wait_page_logic.sv
`timescale 1ns/100ps
`default_nettype none
module tb_static_mem_wait_page_logic
	import smwp_pkg::*;
;
	typedef struct {
		logic       wr, slow, sdrop, fopt, pen;
		logic [1:0] wsel, ps;
		logic [3:0] fc;
		logic [7:0] a1;
		int         dly, wl, n, grow, e0, e1, elow;
	} smwp_row_t;
	logic clk, rst_n, req, req_write, slow_clock, float_opt, page_enable;
	logic byte_access_kind, external_wait_n, req_ready, done, chip_select_n;
	logic read_strobe_n, write_strobe_n, byte_select_mode, page_hit;
	logic wait_frozen, tk;
	logic [1:0] external_wait_select, page_size_field;
	logic [3:0] float_cycles;
	logic [7:0] wdly, wlen;
	logic ce;
	logic [2:0] req_cs, cs_index;
	logic [1:0] data_width;
	logic [SMWP_TW-1:0] rsu, rsw, rsh, crs, crw, rcl, wsu, wsw, cws, cww, wcl;
	logic [SMWP_AW-1:0] req_addr;
	smwp_row_t rows[21];
	smwp_row_t r;
	int num_errors, compares, k, nd, lows, hits, fz;
	int cc[2];
	int lens[2];
	////////////////////////////////////////////////////////////////////////
	// Clock, design and far side
	always #10 clk = !clk;
	smwp_ctrl DUT (.clk, .rst_n, .ce, .req, .req_write,
		.req_cs, .req_addr, .slow_clock, .external_wait_n,
		.external_wait_select, .float_opt, .float_cycles, .page_enable,
		.page_size_field, .data_width, .byte_access_kind,
		.read_strobe_setup(rsu), .read_strobe_width(rsw),
		.read_strobe_hold(rsh),
		.cs_read_setup(crs), .cs_read_width(crw),
		.read_cycle_length(rcl), .write_strobe_setup(wsu),
		.write_strobe_width(wsw), .cs_write_setup(cws),
		.cs_write_width(cww), .write_cycle_length(wcl), .req_ready,
		.done, .chip_select_n, .cs_index, .read_strobe_n,
		.write_strobe_n, .byte_select_mode, .page_hit, .wait_frozen);
	smwp_mem u_mem (.clk, .rst_n, .chip_select_n, .wait_delay(wdly),
		.wait_len(wlen), .external_wait_n);
	////////////////////////////////////////////////////////////////////////
	// Compare and close
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %0h want %0h", $time, seen, exp);
		end
	endtask : check
	task print_verdict;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rows = '{
			'{0,0,0,0,0,0,0,0,8'h40,0,0,1,0,10,0,6},
			'{1,0,0,0,0,0,0,0,8'h40,0,0,1,0,9,0,6},
			'{0,0,0,0,0,0,0,5,8'h40,0,0,1,0,13,0,6},
			'{0,0,0,0,0,0,0,2,8'h40,0,0,1,0,10,0,6},
			'{0,0,0,1,0,0,0,15,8'h40,0,0,1,0,10,0,6},
			'{1,0,0,0,0,0,0,5,8'h40,0,0,1,0,9,0,6},
			'{0,1,0,0,0,0,0,0,8'h40,0,0,1,0,3,0,1},
			'{1,1,0,0,0,0,0,0,8'h40,0,0,1,0,4,0,1},
			'{0,1,1,0,0,0,0,0,8'h40,0,0,1,0,3,0,1},
			'{0,0,0,0,0,0,0,0,8'h40,1,6,1,0,10,0,6},
			'{0,0,0,0,0,3,0,0,8'h40,8,4,1,0,10,0,6},
			'{1,0,0,0,0,2,0,0,8'h40,1,6,1,1,9,0,0},
			'{0,0,0,0,0,3,0,0,8'h40,1,6,1,1,10,0,0},
			'{0,1,0,0,0,3,0,0,8'h40,0,4,1,0,3,0,1},
			'{0,0,0,0,1,0,0,0,8'h41,0,0,2,0,10,7,9},
			'{0,0,0,0,1,0,0,0,8'h44,0,0,2,0,10,10,9},
			'{0,0,0,0,1,0,1,0,8'h47,0,0,2,0,10,7,9},
			'{0,0,0,0,1,0,2,0,8'h50,0,0,2,0,10,10,9},
			'{0,0,0,0,1,0,3,0,8'h5C,0,0,2,0,10,7,9},
			'{0,0,0,0,0,0,0,0,8'h41,0,0,2,0,10,10,6},
			'{0,0,1,0,1,0,3,0,8'h41,0,0,2,0,10,10,9}};
		clk = 0;
		rst_n = 0;
		req = 0;
		req_write = 0;
		slow_clock = 0;
		float_opt = 0;
		page_enable = 0;
		byte_access_kind = 0;
		external_wait_select = 2'h0;
		page_size_field = 2'h0;
		float_cycles = 4'h0;
		wdly = 8'h00;
		wlen = 8'h00;
		req_addr = 26'h000_0040;
		ce = 1;
		req_cs = 3'h1;
		data_width = 2'h2;
		rsu = 9'h001;
		rsw = 9'h006;
		rsh = 9'h002;
		crs = 9'h000;
		crw = 9'h009;
		rcl = 9'h009;
		wsu = 9'h001;
		wsw = 9'h006;
		cws = 9'h000;
		cww = 9'h008;
		wcl = 9'h008;
		num_errors = 0;
		compares = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		foreach (rows[i]) begin
			r = rows[i];
			req_write <= r.wr;
			slow_clock <= r.slow;
			float_opt <= r.fopt;
			page_enable <= r.pen;
			external_wait_select <= r.wsel;
			page_size_field <= r.ps;
			float_cycles <= r.fc;
			wdly <= r.dly[7:0];
			wlen <= r.wl[7:0];
			byte_access_kind <= i[0];
			req_addr <= 26'h000_0040;
			req_cs <= 3'h1;
			req <= 1;
			tk = 0;
			k = 0;
			nd = 0;
			lows = 0;
			hits = 0;
			fz = 0;
			lens = '{0, 0};
			// First request is taken at the coming edge while idle
			@(negedge clk);
			tk = req && req_ready;
			repeat (400) begin
				@(posedge clk);
				if (tk) begin
					cc[k] = 0;
					k++;
					req_addr <= {18'h0_0000, r.a1};
					if (k == r.n)
						req <= 0;
					if (r.sdrop) begin
						slow_clock <= 0;
						req_cs <= 3'h2;
					end
				end
				@(negedge clk);
				for (int j = nd; j < k; j++)
					cc[j]++;
				tk = req && req_ready && k < r.n;
				if (k > 0 && nd == 0 && !(r.wr ? write_strobe_n : read_strobe_n))
					lows++;
				if (page_hit)
					hits++;
				if (wait_frozen)
					fz++;
				if (done) begin
					lens[nd] = cc[nd];
					nd++;
				end
				if (nd == r.n)
					break;
			end
			check(nd, r.n);
			if (nd != r.n)
				print_verdict();
			if (r.grow)
				check(lens[0] > r.e0, 1);
			else
				check(lens[0], r.e0);
			if (r.n == 2)
				check(lens[1], r.e1);
			if (r.elow != 0)
				check(lows, r.elow);
			check(hits, r.e1 == 7);
			check(fz > 0, r.grow);
			check(byte_select_mode, i[0]);
			check(cs_index, (r.sdrop && r.n == 2) ? 3'h2 : 3'h1);
			$display("test %0d done", i);
			repeat (3) @(posedge clk);
		end
		// Clock enable low for five edges stretches a plain read by five
		page_enable <= 0;
		req <= 1;
		@(posedge clk);
		req <= 0;
		repeat (3) @(posedge clk);
		ce <= 0;
		repeat (5) @(posedge clk);
		ce <= 1;
		k = 0;
		repeat (40) begin
			@(negedge clk);
			k++;
			if (done)
				break;
		end
		check(k, 7);
		$display("test clock enable done");
		repeat (3) @(posedge clk);
		rst_n <= 0;
		@(negedge clk);
		check({chip_select_n, read_strobe_n, write_strobe_n, req_ready}, 4'hE);
		@(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		check(req_ready, 1);
		$display("test reset done");
		print_verdict();
	end
endmodule : tb_static_mem_wait_page_logic
`default_nettype wire
